// ===== hw/dts_target_select.sv
// Purpose: target select and status register of a two-wire debug port
// Assumes: adapter clocks the link; target registers live outside
// Notes:   link logic on debug_clock_pin, register logic on clk
//          nothing moves on the link between frames
//
// What this block does
// - The port uses one shared data line and one clock that only the adapter drives.
// - An address write loads the 8-bit select register that steers later data transactions.
// - Select 0x00 reads the part identity, and data writes leave it unchanged.
// - Select 0x01 reads the silicon revision, and data writes leave it unchanged.
// - Select 0x02 reaches the halt control register.
// - Select 0xdf reaches the program enable register.
// - Select 0xbf reaches the program data port.
// - Select 0xb7 reaches the program status register.
// - Select 0xaf reaches the upper program address byte.
// - Select 0xae reaches the lower program address byte.
// - Select 0xa9 reaches checksum byte zero.
// - Selects 0xaa, 0xab and 0xac reach checksum bytes one, two and three.
// - An address read returns a status byte, not the stored select value.
// - Bit 7 of that status byte is high while a memory operation runs.

`timescale 1ns/1ps

`include "dts_regs.svh"

module dts_target_select #(
    parameter logic [7:0] IDENT_VALUE = 8'h5a, // arbitrary value
    parameter logic [7:0] REV_VALUE   = 8'h01  // arbitrary value
) (
    input  wire logic                debug_clock_pin,
    input  wire logic                debug_data_pin_in,
    output logic                     debug_data_pin_out,
    output logic                     debug_data_pin_oe,
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                mem_busy,
    input  wire dts_pkg::dts_rdback_s tgt_rdback,
    output dts_pkg::dts_access_s     tgt_access,
    output logic [7:0]               debug_target_select
);
    import dts_pkg::*;

    // two domains: the link side runs on the
    // adapter clock, in frames and in the idle clocks around reset;
    // the register side runs on clk always.
    // one frame crosses by a request toggle and
    // comes back by an answer toggle. the word
    // riding with a toggle is frozen before it
    // moves and held until the answer returns,
    // so the far side reads it unsynchronised.
    // trade-off: a round trip costs a few
    // cycles of each clock, but needs no buffer.

    // ------------------------------------------------------------
    // link domain, clocked by the adapter clock
    // ------------------------------------------------------------

    // reset carried into the link domain, two flops
    logic lrst_s1_q;
    logic lrst_s2_q;

    // frame state
    // lcnt_q counts bits of a phase and is cleared before the next
    dts_link_e  lstate_q;
    logic [2:0] lcnt_q;
    logic [1:0] lins_q;
    logic [7:0] lshift_q;
    logic       lout_q;
    logic       loe_q;

    // request toggle and the word it carries
    logic       req_tgl_q;
    dts_xfer_s  xfer_q;

    // answer toggle from the core, three flops plus last seen
    logic       ack_s1_q;
    logic       ack_s2_q;
    logic       ack_s3_q;
    logic       ack_seen_q;

    // core side signals read by the link
    // launched on clk, read once settled
    logic       ack_tgl_q;
    logic [7:0] ans_q;

    // decode of the frame being received
    logic       ins_last;
    logic       ins_is_write;
    logic       data_last;
    logic [7:0] wdata_full;
    logic       ack_evt;

    assign ins_last     = (lcnt_q == `DTS_INS_LAST);
    // second instruction bit arrives now, it marks a write
    assign ins_is_write = debug_data_pin_in;
    assign data_last    = (lcnt_q == `DTS_DATA_LAST);
    assign wdata_full   = {debug_data_pin_in, lshift_q[7:1]};
    // answer counts once second and third flop agree
    assign ack_evt      = (ack_s2_q == ack_s3_q) && (ack_s3_q != ack_seen_q);

    // reset synchroniser for the link domain
    // it leaves reset on adapter edges only,
    // so a few idle clocks must follow reset
    always_ff @(posedge debug_clock_pin) begin
        lrst_s1_q <= rst;
        lrst_s2_q <= lrst_s1_q;
    end

    // answer toggle synchroniser
    // only flop two reads flop one, which may
    // still be settling when it is sampled
    always_ff @(posedge debug_clock_pin) begin
        if (lrst_s2_q) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // frame state machine; the clock only runs while the adapter
    // talks, so every step waits on an adapter edge
    //   idle : waits for a high start bit
    //   ins  : two instruction bits, lsb first
    //   wdat : eight write bits, lsb first
    //   wait : line low until the core answers
    //   ready: one high bit, answer is there
    //   rdat : eight read bits, then let go
    //   other: back to idle, line released
    // limitation: a frame cut off mid way
    // stays put until a link reset clears it
    always_ff @(posedge debug_clock_pin) begin
        if (lrst_s2_q) begin
            lstate_q   <= DTS_L_IDLE;
            lcnt_q     <= 3'h0;
            lins_q     <= 2'h0;
            lshift_q   <= 8'h00;
            lout_q     <= 1'b0;
            loe_q      <= 1'b0;
            req_tgl_q  <= 1'b0;
            xfer_q     <= '0;
            ack_seen_q <= 1'b0;
        end else begin
            case (lstate_q)
                DTS_L_IDLE: begin
                    // a high level on the data line opens a frame
                    if (debug_data_pin_in) begin
                        lstate_q <= DTS_L_INS;
                        lcnt_q   <= 3'h0;
                    end
                end
                DTS_L_INS: begin
                    lins_q[lcnt_q[0]] <= debug_data_pin_in;
                    lcnt_q            <= lcnt_q + 3'h1;
                    if (ins_last) begin
                        lcnt_q <= 3'h0;
                        if (ins_is_write) begin
                            lstate_q <= DTS_L_WDAT;
                        end else begin
                            // reads go straight to the core
                            xfer_q    <= '{ins: {1'b0, lins_q[0]}, data: 8'h00};
                            req_tgl_q <= ~req_tgl_q;
                            lstate_q  <= DTS_L_WAIT;
                            lout_q    <= 1'b0;
                            loe_q     <= 1'b1;
                        end
                    end
                end
                DTS_L_WDAT: begin
                    lshift_q <= wdata_full;
                    lcnt_q   <= lcnt_q + 3'h1;
                    if (data_last) begin
                        // word is held stable until the answer returns
                        xfer_q    <= '{ins: lins_q, data: wdata_full};
                        req_tgl_q <= ~req_tgl_q;
                        lstate_q  <= DTS_L_WAIT;
                        lout_q    <= 1'b0;
                        loe_q     <= 1'b1;
                    end
                end
                DTS_L_WAIT: begin
                    // line held low until the core has acted
                    // no limit here; the adapter owns timeouts
                    if (ack_evt) begin
                        ack_seen_q <= ack_s3_q;
                        lout_q     <= 1'b1;
                        lstate_q   <= DTS_L_READY;
                    end
                end
                DTS_L_READY: begin
                    if (lins_q[1]) begin
                        // writes end after the ready bit
                        lout_q   <= 1'b0;
                        loe_q    <= 1'b0;
                        lstate_q <= DTS_L_IDLE;
                    end else begin
                        // ans_q is stable since the core toggled
                        lout_q   <= ans_q[0];
                        lshift_q <= {1'b0, ans_q[7:1]};
                        lcnt_q   <= 3'h0;
                        lstate_q <= DTS_L_RDAT;
                    end
                end
                DTS_L_RDAT: begin
                    // bit 7 goes out at step 6 with no shift
                    if (lcnt_q == 3'h6) begin
                        lout_q   <= lshift_q[0];
                        lcnt_q   <= lcnt_q + 3'h1;
                    end else if (data_last) begin
                        // release the line for the adapter
                        lout_q   <= 1'b0;
                        loe_q    <= 1'b0;
                        lstate_q <= DTS_L_IDLE;
                    end else begin
                        lout_q   <= lshift_q[0];
                        lshift_q <= {1'b0, lshift_q[7:1]};
                        lcnt_q   <= lcnt_q + 3'h1;
                    end
                end
                default: begin
                    lstate_q <= DTS_L_IDLE;
                    loe_q    <= 1'b0;
                end
            endcase
        end
    end

    // oe high means the device drives the pin;
    // out only matters while oe is high
    assign debug_data_pin_out = lout_q;
    assign debug_data_pin_oe  = loe_q;

    // ------------------------------------------------------------
    // core domain, clocked by clk
    // ------------------------------------------------------------

    // the select lives on clk so that a strobe
    // and the select it came from stay paired

    // request toggle synchroniser, three flops plus last seen
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic req_seen_q;

    logic [7:0]  sel_q;
    dts_access_s acc_q;

    logic        req_evt;
    dts_target_e sel_tgt;
    logic [7:0]  rd_value;
    logic        tgt_writable;
    logic [7:0]  status_byte;

    assign req_evt = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);

    // select value to target; unlisted values fall to none
    // every offset is distinct, so the chain
    // order does not matter
    assign sel_tgt =
        (sel_q == `DTS_OFS_IDENT) ? DTS_T_IDENT :
        (sel_q == `DTS_OFS_REV)   ? DTS_T_REV   :
        (sel_q == `DTS_OFS_HALT)  ? DTS_T_HALT  :
        (sel_q == `DTS_OFS_PEN)   ? DTS_T_PEN   :
        (sel_q == `DTS_OFS_PDATA) ? DTS_T_PDATA :
        (sel_q == `DTS_OFS_PSTAT) ? DTS_T_PSTAT :
        (sel_q == `DTS_OFS_AHI)   ? DTS_T_AHI   :
        (sel_q == `DTS_OFS_ALO)   ? DTS_T_ALO   :
        (sel_q == `DTS_OFS_CHECKSUM_BYTE_ZERO)  ? DTS_T_CHECKSUM_BYTE_ZERO  :
        (sel_q == `DTS_OFS_CHECKSUM_BYTE_ONE)  ? DTS_T_CHECKSUM_BYTE_ONE  :
        (sel_q == `DTS_OFS_CHECKSUM_BYTE_TWO)  ? DTS_T_CHECKSUM_BYTE_TWO  :
        (sel_q == `DTS_OFS_CHECKSUM_BYTE_THREE)  ? DTS_T_CHECKSUM_BYTE_THREE  :
        DTS_T_NONE;

    // read data of the selected target
    // sampled at request time, so a target
    // that moves later is not seen this frame
    assign rd_value =
        (sel_tgt == DTS_T_IDENT) ? IDENT_VALUE        :
        (sel_tgt == DTS_T_REV)   ? REV_VALUE          :
        (sel_tgt == DTS_T_HALT)  ? tgt_rdback.halt    :
        (sel_tgt == DTS_T_PEN)   ? tgt_rdback.pen     :
        (sel_tgt == DTS_T_PDATA) ? tgt_rdback.pdata   :
        (sel_tgt == DTS_T_PSTAT) ? tgt_rdback.pstat   :
        (sel_tgt == DTS_T_AHI)   ? tgt_rdback.ahi     :
        (sel_tgt == DTS_T_ALO)   ? tgt_rdback.alo     :
        (sel_tgt == DTS_T_CHECKSUM_BYTE_ZERO)  ? tgt_rdback.crc[0]  :
        (sel_tgt == DTS_T_CHECKSUM_BYTE_ONE)  ? tgt_rdback.crc[1]  :
        (sel_tgt == DTS_T_CHECKSUM_BYTE_TWO)  ? tgt_rdback.crc[2]  :
        (sel_tgt == DTS_T_CHECKSUM_BYTE_THREE)  ? tgt_rdback.crc[3]  :
        8'h00;

    // read only and unlisted targets never see a write strobe
    // status counts as read only: the engine
    // owns its bits and a write would fight it
    assign tgt_writable = (sel_tgt != DTS_T_IDENT) &&
                          (sel_tgt != DTS_T_REV)   &&
                          (sel_tgt != DTS_T_PSTAT) &&
                          (sel_tgt != DTS_T_NONE);

    // status byte: busy on top, other bits fixed at zero
    // the adapter judges bit 7 only; the low
    // bits read zero rather than float.
    // mem_busy is a clk level, no sync needed
    assign status_byte = {mem_busy, 7'h00};

    // request toggle synchroniser
    // a toggle counts once flops two and three
    // agree, so a half-caught edge counts once
    always_ff @(posedge clk) begin
        if (rst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // select register, loaded by address writes only
    // data frames never move it
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q <= `DTS_SEL_RESET;
        end else if (req_evt && (xfer_q.ins == `DTS_INS_AWRITE)) begin
            sel_q <= xfer_q.data;
        end
    end

    // answer path: xfer_q is stable while the request is pending,
    // so reading it here across domains is safe
    // address reads report status, not select;
    // writes leave ans_q alone
    always_ff @(posedge clk) begin
        if (rst) begin
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            ans_q      <= 8'h00;
        end else if (req_evt) begin
            req_seen_q <= req_s3_q;
            ack_tgl_q  <= ~ack_tgl_q;
            if (xfer_q.ins == `DTS_INS_AREAD) begin
                ans_q <= status_byte;
            end else if (xfer_q.ins == `DTS_INS_DREAD) begin
                ans_q <= rd_value;
            end
        end
    end

    // one cycle strobes towards the target registers
    // rd fires on every data read so that the
    // data port can step to its next byte;
    // tgt and data are refreshed every cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= '{wr: 1'b0, rd: 1'b0, tgt: DTS_T_IDENT, data: 8'h00};
        end else begin
            acc_q.wr   <= req_evt && (xfer_q.ins == `DTS_INS_DWRITE) && tgt_writable;
            acc_q.rd   <= req_evt && (xfer_q.ins == `DTS_INS_DREAD);
            acc_q.tgt  <= sel_tgt;
            acc_q.data <= xfer_q.data;
        end
    end

    // outputs straight from their flops
    assign tgt_access          = acc_q;
    assign debug_target_select = sel_q;

endmodule

// ===== include/dts_regs.svh
// Purpose: constants for the debug target select block
// Assumes: included by bare name from the design file
// Notes:   register offsets are the select values the adapter loads

`ifndef DTS_REGS_SVH
`define DTS_REGS_SVH

// select register reset value
`define DTS_SEL_RESET    8'h00

// target offsets
`define DTS_OFS_IDENT    8'h00
`define DTS_OFS_REV      8'h01
`define DTS_OFS_HALT     8'h02
`define DTS_OFS_PEN      8'hdf
`define DTS_OFS_PDATA    8'hbf
`define DTS_OFS_PSTAT    8'hb7
`define DTS_OFS_AHI      8'haf
`define DTS_OFS_ALO      8'hae
`define DTS_OFS_CHECKSUM_BYTE_ZERO     8'ha9
`define DTS_OFS_CHECKSUM_BYTE_ONE     8'haa
`define DTS_OFS_CHECKSUM_BYTE_TWO     8'hab
`define DTS_OFS_CHECKSUM_BYTE_THREE     8'hac

// status byte field: busy flag position
`define DTS_BUSY_BIT     7

// frame instruction codes, sent lsb first
`define DTS_INS_DREAD    2'h0
`define DTS_INS_AREAD    2'h1
`define DTS_INS_DWRITE   2'h2
`define DTS_INS_AWRITE   2'h3

// link bit counts, as last index
`define DTS_INS_LAST     3'h1
`define DTS_DATA_LAST    3'h7

`endif

// ===== include/dts_pkg.sv
// Purpose: types shared by the debug target select block
// Assumes: nothing beyond the language
// Notes:   constants live in dts_regs.svh

package dts_pkg;

    // internal register reached by data transactions
    typedef enum logic [3:0] {
        DTS_T_IDENT,
        DTS_T_REV,
        DTS_T_HALT,
        DTS_T_PEN,
        DTS_T_PDATA,
        DTS_T_PSTAT,
        DTS_T_AHI,
        DTS_T_ALO,
        DTS_T_CHECKSUM_BYTE_ZERO,
        DTS_T_CHECKSUM_BYTE_ONE,
        DTS_T_CHECKSUM_BYTE_TWO,
        DTS_T_CHECKSUM_BYTE_THREE,
        DTS_T_NONE
    } dts_target_e;

    // link side state machine
    typedef enum logic [2:0] {
        DTS_L_IDLE,
        DTS_L_INS,
        DTS_L_WDAT,
        DTS_L_WAIT,
        DTS_L_READY,
        DTS_L_RDAT
    } dts_link_e;

    // one frame handed from link to core
    typedef struct packed {
        logic [1:0] ins;
        logic [7:0] data;
    } dts_xfer_s;

    // contents of the writable and status targets
    typedef struct packed {
        logic [7:0]      halt;
        logic [7:0]      pen;
        logic [7:0]      pdata;
        logic [7:0]      pstat;
        logic [7:0]      ahi;
        logic [7:0]      alo;
        logic [3:0][7:0] crc;
    } dts_rdback_s;

    // access strobe towards the target registers
    typedef struct packed {
        logic        wr;
        logic        rd;
        dts_target_e tgt;
        logic [7:0]  data;
    } dts_access_s;

endpackage

// ===== dv/dts_target_select_props.sv
// Purpose: assertions on the ports of the debug target select block
// Assumes: bound to every instance of the design
// Notes:   link checks count adapter clock edges, which run in frames and in the idle clocks around reset

`timescale 1ns/1ps

module dts_target_select_props (
    input wire logic                 debug_clock_pin,
    input wire logic                 debug_data_pin_in,
    input wire logic                 debug_data_pin_out,
    input wire logic                 debug_data_pin_oe,
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 mem_busy,
    input wire dts_pkg::dts_rdback_s tgt_rdback,
    input wire dts_pkg::dts_access_s tgt_access,
    input wire logic [7:0]           debug_target_select
);
    import dts_pkg::*;

    // target expected from the select value alone; unlisted values reach nothing
    function automatic dts_target_e dec(input logic [7:0] s);
        case (s)
            8'h00: return DTS_T_IDENT;
            8'h01: return DTS_T_REV;
            8'h02: return DTS_T_HALT;
            8'hdf: return DTS_T_PEN;
            8'hbf: return DTS_T_PDATA;
            8'hb7: return DTS_T_PSTAT;
            8'haf: return DTS_T_AHI;
            8'hae: return DTS_T_ALO;
            8'ha9: return DTS_T_CHECKSUM_BYTE_ZERO;
            8'haa: return DTS_T_CHECKSUM_BYTE_ONE;
            8'hab: return DTS_T_CHECKSUM_BYTE_TWO;
            8'hac: return DTS_T_CHECKSUM_BYTE_THREE;
            default: return DTS_T_NONE;
        endcase
    endfunction

    // core side
    a_sel_reset_zero: assert property (@(posedge clk) rst |=> debug_target_select == 8'h00)
        else $error("select register not zero after reset");
    a_access_reset: assert property (@(posedge clk) rst |=> !tgt_access.wr && !tgt_access.rd)
        else $error("access strobe during reset");
    a_no_ro_write: assert property (@(posedge clk) disable iff (rst)
        tgt_access.wr |-> !(tgt_access.tgt inside {DTS_T_IDENT, DTS_T_REV, DTS_T_PSTAT, DTS_T_NONE}))
        else $error("write strobe towards a read-only or unlisted target");
    a_target_decode: assert property (@(posedge clk)
        disable iff (rst) (tgt_access.wr || tgt_access.rd) |-> tgt_access.tgt == dec(debug_target_select))
        else $error("access target does not match select value");
    a_sel_quiet: assert property (@(posedge clk) disable iff (rst)
        (tgt_access.wr || tgt_access.rd) |-> $stable(debug_target_select) ##1 $stable(debug_target_select))
        else $error("select changed around a data access");
    a_wr_pulse: assert property (@(posedge clk) disable iff (rst) tgt_access.wr |=> !tgt_access.wr)
        else $error("write strobe longer than one cycle");

    // link side: the device only drives the shared line in its turn
    a_link_reset: assert property (@(posedge debug_clock_pin) rst [*5] |-> !debug_data_pin_oe)
        else $error("data line driven during reset");
    a_wait_low: assert property (@(posedge debug_clock_pin) disable iff (rst)
        $rose(debug_data_pin_oe) |-> !debug_data_pin_out)
        else $error("turnaround does not start with a low wait bit");
    a_ready_bound: assert property (@(posedge debug_clock_pin) disable iff (rst)
        $rose(debug_data_pin_oe) |-> ##[1:12] (debug_data_pin_oe && debug_data_pin_out))
        else $error("ready bit missing after turnaround");
endmodule

bind dts_target_select dts_target_select_props u_dts_target_select_props (
    .debug_clock_pin    (debug_clock_pin),
    .debug_data_pin_in  (debug_data_pin_in),
    .debug_data_pin_out (debug_data_pin_out),
    .debug_data_pin_oe  (debug_data_pin_oe),
    .clk                (clk),
    .rst                (rst),
    .mem_busy           (mem_busy),
    .tgt_rdback         (tgt_rdback),
    .tgt_access         (tgt_access),
    .debug_target_select(debug_target_select)
);

// ===== dv/dts_adapter_model.sv
// Purpose: behavioural programming adapter on the two-wire link
// Assumes: sees only the shared data line, never the device's enables
// Notes:   link clock stands low between frames

`timescale 1ns/1ps

module dts_adapter_model (
    output logic      link_clk,
    output logic      drv_oe,
    output logic      drv_out,
    input wire logic  line
);
    initial begin
        link_clk = 1'b0;
        drv_oe = 1'b1;
        drv_out = 1'b0;
    end

    // one link cycle; data is changed only while the clock is low
    task automatic pulse();
        #62.5 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
    endtask

    task automatic send(input logic b);
        drv_oe = 1'b1;
        drv_out = b;
        pulse();
    endtask

    task automatic idle(input int n);
        drv_oe = 1'b1;
        drv_out = 1'b0;
        repeat (n) pulse();
    endtask

    // start, opcode lsb first, write byte, then hand the line over until ready
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        send(1'b1);
        send(ins[0]);
        send(ins[1]);
        if (ins[1]) begin
            for (int i = 0; i < 8; i++) send(wd[i]);
        end
        drv_oe = 1'b0;
        ok = 1'b0;
        rd = 8'h00;
        for (int n = 0; n < 40 && !ok; n++) begin
            pulse();
            ok = (line === 1'b1);
        end
        if (ok && !ins[1]) begin
            for (int i = 0; i < 8; i++) begin
                pulse();
                rd[i] = line;
            end
        end
        // the line stays released; the next start bit takes it back,
        // so the data pin is never set twice in one step
        pulse();
    endtask
    // status byte: only bit 7 is judged by the callers
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for the debug target select block
// Assumes: adapter model drives the link, bench drives the core side
// Notes:   target contents are fixed distinct bytes

`timescale 1ns/1ps

module tb;
    import dts_pkg::*;

    logic        clk;
    logic        rst;
    logic        mem_busy;
    dts_rdback_s rdback;
    dts_access_s acc;
    dts_access_s last_wr;
    logic [7:0]  sel;
    logic        link_clk;
    logic        ad_oe;
    logic        ad_out;
    logic        dev_oe;
    logic        dev_out;
    logic        junk_q;
    wire         line;
    int          bad_count;
    int          n_compared;
    int          wr_cnt;
    int          rd_cnt;
    logic [7:0]  ofs [12] = '{8'h00, 8'h01, 8'h02, 8'hdf, 8'hbf, 8'hb7, 8'haf, 8'hae, 8'ha9, 8'haa, 8'hab, 8'hac};
    logic [7:0]  val [12] = '{8'h3c, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h70, 8'h71, 8'h72, 8'h73};

    initial clk = 1'b0;
    always #20 clk = ~clk;

    // a released line shows a changing pattern, not a remembered level
    initial junk_q = 1'b0;
    always @(posedge clk) junk_q <= ~junk_q;
    assign line = dev_oe ? dev_out : (ad_oe ? ad_out : junk_q);

    // count access strobes towards the targets
    always @(posedge clk) begin
        if (acc.wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= acc;
        end
        if (acc.rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
    end

    dts_target_select #(.IDENT_VALUE(8'h3c), .REV_VALUE(8'h07)) u_dts_target_select (
        .debug_clock_pin    (link_clk),
        .debug_data_pin_in  (line),
        .debug_data_pin_out (dev_out),
        .debug_data_pin_oe  (dev_oe),
        .clk                (clk),
        .rst                (rst),
        .mem_busy           (mem_busy),
        .tgt_rdback         (rdback),
        .tgt_access         (acc),
        .debug_target_select(sel)
    );

    dts_adapter_model u_dts_adapter_model (
        .link_clk(link_clk),
        .drv_oe  (ad_oe),
        .drv_out (ad_out),
        .line    (line)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        logic ok;
        u_dts_adapter_model.frame(ins, wd, rd, ok);
        check("frame ready", {7'h0, ok}, 8'h01);
    endtask

    task automatic t_reset();
        logic [7:0] rd;
        check("select at reset", sel, 8'h00);
        xfer(2'h0, 8'h00, rd);
        check("first read", rd, 8'h3c);
        $display("test reset done");
    endtask

    task automatic t_table();
        int w;
        int r;
        logic [7:0] rd;
        for (int i = 0; i < 12; i++) begin
            xfer(2'h3, ofs[i], rd);
            check("select", sel, ofs[i]);
            w = wr_cnt;
            xfer(2'h2, 8'hc0 + 8'(i), rd);
            if (i == 0 || i == 1 || i == 5) begin
                check("ro write", 8'(wr_cnt - w), 8'h00);
            end else begin
                check("wr count", 8'(wr_cnt - w), 8'h01);
                check("wr target", {4'h0, last_wr.tgt}, 8'(i));
                check("wr data", last_wr.data, 8'hc0 + 8'(i));
            end
            r = rd_cnt;
            xfer(2'h0, 8'h00, rd);
            check("read", rd, val[i]);
            check("rd count", 8'(rd_cnt - r), 8'h01);
        end
        $display("test table done");
    endtask

    task automatic t_unlisted();
        int w;
        logic [7:0] rd;
        xfer(2'h3, 8'h55, rd);
        w = wr_cnt;
        xfer(2'h2, 8'h9c, rd);
        check("unlisted write", 8'(wr_cnt - w), 8'h00);
        xfer(2'h0, 8'h00, rd);
        check("unlisted read", rd, 8'h00);
        $display("test unlisted done");
    endtask

    // select values chosen so that bit 7 of the select differs from the busy flag
    task automatic t_status();
        logic [7:0] rd;
        xfer(2'h3, 8'haf, rd);
        @(negedge clk) mem_busy = 1'b0;
        xfer(2'h1, 8'h00, rd);
        check("idle status", {7'h0, rd[7]}, 8'h00);
        check("select kept", sel, 8'haf);
        xfer(2'h3, 8'h02, rd);
        @(negedge clk) mem_busy = 1'b1;
        xfer(2'h1, 8'h00, rd);
        check("busy status", {7'h0, rd[7]}, 8'h01);
        @(negedge clk) mem_busy = 1'b0;
        $display("test status done");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        mem_busy = 1'b0;
        rdback = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h73, 8'h72, 8'h71, 8'h70};
        bad_count = 0;
        n_compared = 0;
        wr_cnt = 0;
        rd_cnt = 0;
        fork
            u_dts_adapter_model.idle(6);
            repeat (20) @(negedge clk);
        join
        rst = 1'b0;
        u_dts_adapter_model.idle(4);
        t_reset();
        t_table();
        t_unlisted();
        t_status();
        finish_test();
    end

    // a hung handshake ends the run after several times the expected length
    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end
endmodule
